// file: core/qdcr_bank.sv
// Configuration and trigger register bank of a four-channel output converter.
// Assumes a host-side serial front end that presents decoded register reads and
// writes, and an external nonvolatile word store with same-cycle read data.
`timescale 1ns/10ps
`default_nettype none
module qdcr_bank
  import qdcr_pkg::*;
(
  input  wire logic        clk,                        // 100 MHz clock
  input  wire logic        reset_n,                    // Synchronous reset
  input  wire logic        ce,                         // Clock enable
  input  wire logic        reg_write,                  // Register write strobe
  input  wire logic        reg_read,                   // Register read strobe
  input  wire logic [7:0]  reg_addr,                   // Register address
  input  wire logic [15:0] reg_wdata,                  // Write data
  output logic      [15:0] reg_rdata,                  // Read data
  output logic             reg_rvalid,                 // Read data valid pulse
  input  wire logic [15:0] nvm_rd_data,                // Stored word at nvm_index
  output logic      [2:0]  nvm_index,                  // Stored word index
  output logic             nvm_wr_en,                  // Store word strobe
  output logic      [15:0] nvm_wr_data,                // Word to store
  output logic             nvm_busy,                   // Load or store in progress
  input  wire logic        general_input_pin,          // General-purpose pin level
  output logic             general_pin_out,            // Pin output value
  output logic             general_pin_oe,             // Pin output enable
  input  wire logic [15:0] status_sources,             // Internal status functions
  output logic      [3:0]  gen_run,                    // Waveform generator running
  output logic             comparator_latching,        // Window comparator latches
  output logic             device_locked,              // Configuration locked
  output logic             fault_dump_read_disable,    // Dump read path off
  output logic             internal_ref_enable,        // Internal reference on
  output logic      [7:0]  voltage_output_power,       // Ch3..0 two-bit power codes
  output logic      [3:0]  current_output_power_down,  // Ch3..0 current power down
  output logic      [11:0] chan_ref_gain,              // Ch3..0 reference and gain codes
  output logic      [3:0]  chan_open_drain,            // Comparator output not push-pull
  output logic      [3:0]  chan_comp_to_pin,           // Comparator result to pin
  output logic      [3:0]  chan_feedback_low_z,        // Feedback input not high-Z
  output logic      [3:0]  chan_comp_invert,           // Comparator output inverted
  output logic      [3:0]  chan_comp_enable,           // Comparator mode
  output logic             output_load_strobe,         // Load channel outputs pulse
  output logic             output_clear,               // Clear outputs pulse
  output logic             fault_dump_start,           // Fault dump pulse
  output logic             protect_start,              // Protection function pulse
  output logic             fault_dump_read_start       // Fault-dump read pulse
);

  qdcr_state_t s;         // Current state
  qdcr_state_t next_s;    // Next state
  logic        in_level;  // Conditioned pin level
  logic        in_rise;   // Conditioned rising edge
  logic [3:0]  wr_dec;    // Write address decode {hit, slot}
  logic [3:0]  rd_dec;    // Read address decode {hit, slot}

  // Map an address to its storage slot; the trigger register has no slot
  function automatic logic [3:0] decode_slot(input logic [7:0] addr);
    unique case (addr)
      QDCR_ADDR_POWER: decode_slot = {1'b1, QDCR_SLOT_POWER};
      QDCR_ADDR_PIN:   decode_slot = {1'b1, QDCR_SLOT_PIN};
      QDCR_ADDR_CH0:   decode_slot = {1'b1, QDCR_SLOT_CH0};
      QDCR_ADDR_CH1:   decode_slot = {1'b1, 3'h3};
      QDCR_ADDR_CH2:   decode_slot = {1'b1, 3'h4};
      QDCR_ADDR_CH3:   decode_slot = {1'b1, QDCR_SLOT_LAST};
      default:         decode_slot = 4'h0;
    endcase
  endfunction : decode_slot

  // Bits that exist in a slot; don't-care bits stay zero everywhere
  function automatic logic [15:0] slot_mask(input logic [2:0] slot);
    if (slot == QDCR_SLOT_POWER) begin
      slot_mask = QDCR_POWER_MASK;
    end else if (slot == QDCR_SLOT_PIN) begin
      slot_mask = QDCR_PIN_MASK;
    end else begin
      slot_mask = QDCR_CH_MASK;
    end
  endfunction : slot_mask

  // State after power-on or the reset key: defaults, then a reload pass
  function automatic qdcr_state_t reset_state();
    qdcr_state_t r;
    r                       = '0;
    r.fsm                   = QDCR_LOAD;
    r.regs[QDCR_SLOT_POWER] = QDCR_POWER_RST;
    r.regs[QDCR_SLOT_PIN]   = QDCR_PIN_RST;
    for (int c = 0; c < 4; c++) begin
      r.regs[QDCR_SLOT_CH0 + 3'(c)] = QDCR_CH_RST;
    end
    reset_state = r;
  endfunction : reset_state

  assign wr_dec = decode_slot(reg_addr);
  assign rd_dec = decode_slot(reg_addr);

  // Pin conditioning; the filter is bypassed unless enabled
  qdcr_input_filter u_filter (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .filter_en (s.regs[QDCR_SLOT_PIN][QDCR_PIN_FILTER_BIT]),
    .pin_in    (general_input_pin),
    .level     (in_level),
    .rise      (in_rise)
  );

  // Next-state logic: pin events, nonvolatile sequencer, host accesses
  always_comb begin
    next_s               = s;
    next_s.rvalid        = 1'b0;
    next_s.load_pulse    = 1'b0;
    next_s.clear_pulse   = 1'b0;
    next_s.fdump_pulse   = 1'b0;
    next_s.protect_pulse = 1'b0;
    next_s.fdread_pulse  = 1'b0;
    // Selected status function drives the pin value
    next_s.pin_out = status_sources[s.regs[QDCR_SLOT_PIN][QDCR_PIN_STAT_LSB +: 4]];
    // Start/stop toggles only the channels enabled for the input function
    if (in_rise && s.regs[QDCR_SLOT_PIN][QDCR_PIN_IN_BIT]
        && s.regs[QDCR_SLOT_PIN][QDCR_PIN_FUNC_LSB +: 4] == QDCR_FUNC_START) begin
      next_s.run = s.run ^ s.regs[QDCR_SLOT_PIN][QDCR_PIN_CHEN_LSB +: 4];
    end
    unique case (s.fsm)
      QDCR_LOAD: begin
        // One stored word per cycle; host writes are ignored meanwhile
        next_s.regs[s.idx] = nvm_rd_data & slot_mask(s.idx);
        next_s.idx         = s.idx + 3'h1;
        if (s.idx == QDCR_SLOT_LAST) begin
          next_s.fsm = QDCR_IDLE;
          next_s.idx = 3'h0;
        end
      end
      QDCR_SAVE: begin
        // Word leaves through nvm_wr_data in this cycle
        next_s.idx = s.idx + 3'h1;
        if (s.idx == QDCR_SLOT_LAST) begin
          next_s.fsm = QDCR_IDLE;
          next_s.idx = 3'h0;
        end
      end
      QDCR_IDLE: begin
        if (reg_write && reg_addr == QDCR_ADDR_TRIG) begin
          if (reg_wdata[QDCR_TRIG_RESET_LSB +: 4] == QDCR_RESET_KEY) begin
            next_s = reset_state();
          end else begin
            // Keys act even while locked; the rest needs an unlocked device
            if (reg_wdata[QDCR_TRIG_UNLOCK_LSB +: 4] == QDCR_UNLOCK_KEY) begin
              next_s.regs[QDCR_SLOT_POWER][QDCR_POW_LOCK_BIT] = 1'b0;
            end
            if (!s.regs[QDCR_SLOT_POWER][QDCR_POW_LOCK_BIT]) begin
              next_s.load_pulse    = reg_wdata[QDCR_TRIG_LOAD_BIT];
              next_s.clear_pulse   = reg_wdata[QDCR_TRIG_CLEAR_BIT];
              next_s.fdump_pulse   = reg_wdata[QDCR_TRIG_FDUMP_BIT];
              next_s.protect_pulse = reg_wdata[QDCR_TRIG_PROT_BIT];
              next_s.fdread_pulse  = reg_wdata[QDCR_TRIG_FDREAD_BIT];
              // Store wins when both store and reload are asked at once
              if (reg_wdata[QDCR_TRIG_STORE_BIT]) begin
                next_s.fsm = QDCR_SAVE;
              end else if (reg_wdata[QDCR_TRIG_RELOAD_BIT]) begin
                next_s.fsm = QDCR_LOAD;
              end
            end
          end
        end else if (reg_write && wr_dec[3]
                     && !s.regs[QDCR_SLOT_POWER][QDCR_POW_LOCK_BIT]) begin
          next_s.regs[wr_dec[2:0]] = reg_wdata & slot_mask(wr_dec[2:0]);
          // Lock is set by writing one and cleared only by the unlock key, the reset key or reset_n
          if (wr_dec[2:0] == QDCR_SLOT_POWER) begin
            next_s.regs[QDCR_SLOT_POWER][QDCR_POW_LOCK_BIT] = reg_wdata[QDCR_POW_LOCK_BIT];
          end
        end
      end
      default: begin
        next_s.fsm = QDCR_IDLE;  // Unused state code recovers to idle
      end
    endcase
    // Reads answer in every state; the trigger register and holes read zero
    if (reg_read) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_dec[3] ? s.regs[rd_dec[2:0]] : 16'h0000;
    end
  end

  // State register; reset wins over the clock enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= reset_state();
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Register-bank outputs; rdata, rvalid and index straight from flip-flops, the rest decoded from state
  assign reg_rdata   = s.rdata;
  assign reg_rvalid  = s.rvalid;
  assign nvm_index   = s.idx;
  assign nvm_wr_en   = (s.fsm == QDCR_SAVE);
  assign nvm_wr_data = s.regs[s.idx];
  assign nvm_busy    = (s.fsm != QDCR_IDLE);

  // Pin drive; the driver is off unless output mode is set
  assign general_pin_out = s.pin_out;
  assign general_pin_oe  = s.regs[QDCR_SLOT_PIN][QDCR_PIN_OUT_BIT];
  assign gen_run         = s.run;

  // Common power and reference controls
  assign comparator_latching     = s.regs[QDCR_SLOT_POWER][QDCR_POW_LATCH_BIT];
  assign device_locked           = s.regs[QDCR_SLOT_POWER][QDCR_POW_LOCK_BIT];
  assign fault_dump_read_disable = s.regs[QDCR_SLOT_POWER][QDCR_POW_FDR_BIT];
  assign internal_ref_enable     = s.regs[QDCR_SLOT_POWER][QDCR_POW_REF_BIT];

  // Per-channel power fields sit in three-bit groups, channel 0 lowest
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      voltage_output_power[2*c +: 2]  = s.regs[QDCR_SLOT_POWER][3*c+1 +: 2];
      current_output_power_down[c]    = s.regs[QDCR_SLOT_POWER][3*c];
    end
  end

  // Per-channel output and comparator settings
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      chan_ref_gain[3*c +: 3] = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_REF_LSB +: 3];
      chan_open_drain[c]      = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_ODRAIN_BIT];
      chan_comp_to_pin[c]     = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_TOPIN_BIT];
      chan_feedback_low_z[c]  = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_FBZ_BIT];
      chan_comp_invert[c]     = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_INV_BIT];
      chan_comp_enable[c]     = s.regs[QDCR_SLOT_CH0 + 3'(c)][QDCR_CH_EN_BIT];
    end
  end

  // One-shot action pulses
  assign output_load_strobe    = s.load_pulse;
  assign output_clear          = s.clear_pulse;
  assign fault_dump_start      = s.fdump_pulse;
  assign protect_start         = s.protect_pulse;
  assign fault_dump_read_start = s.fdread_pulse;

  // Checks below assume ce held high across the cycles they span
  trigger_reads_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && reg_read && reg_addr == QDCR_ADDR_TRIG) |=> (reg_rvalid && reg_rdata == 16'h0000))
    else $error("trigger register read back nonzero");

  dont_care_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && reg_read && reg_addr == QDCR_ADDR_PIN) |=> (reg_rdata[14] == 1'b0))
    else $error("pin register don't-care bit read as one");

  locked_write_blocked_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && device_locked && reg_write && reg_addr == QDCR_ADDR_PIN)
      |=> $stable(general_pin_oe))
    else $error("pin register changed while locked");

  unlock_key_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[15:8] == 8'h50) |=> !device_locked)
    else $error("unlock key did not unlock");

  reset_key_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[11:8] == 4'ha) |=> (nvm_busy && nvm_index == 3'h0 && gen_run == 4'h0))
    else $error("reset key did not restart the bank");

  load_pulse_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && !device_locked && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[15:8] == 8'h00 && reg_wdata[7]) |=> output_load_strobe)
    else $error("load strobe missing after trigger");

  clear_one_shot_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && output_clear && !reg_write) |=> !output_clear)
    else $error("clear pulse longer than one cycle");

  store_walk_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && !device_locked && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[15:8] == 8'h00 && reg_wdata[1]) |=> nvm_wr_en [*6] ##1 !nvm_busy)
    else $error("store pass not six words long");

  reload_walk_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && !device_locked && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[15:8] == 8'h00 && reg_wdata[1:0] == 2'b01)
      |=> (nvm_busy && !nvm_wr_en) [*6] ##1 !nvm_busy)
    else $error("reload pass not six words long");

  reset_reload_a: assert property (
    @(posedge clk)
    $rose(reset_n) |-> (nvm_busy && nvm_index == 3'h0 && !nvm_wr_en))
    else $error("no reload after reset");

  // The fault-dump, protect and dump-read bits each map to their own pulse; the reset key field must be clear
  action_pulses_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && !device_locked && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[15:8] == 8'h00)
      |=> (fault_dump_start == $past(reg_wdata[4]) && protect_start == $past(reg_wdata[3])
           && fault_dump_read_start == $past(reg_wdata[2])))
    else $error("fault or protect pulse does not follow trigger bits");

  // A locked device drops the load, clear, store and reload actions of any trigger write but the reset key
  locked_trigger_dropped_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && !nvm_busy && device_locked && reg_write && reg_addr == QDCR_ADDR_TRIG
     && reg_wdata[11:8] != 4'ha) |=> (!output_load_strobe && !output_clear && !nvm_busy))
    else $error("trigger action taken while locked");

  // A qualified pin edge toggles exactly the enabled channels
  run_toggle_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ce && in_rise && s.regs[QDCR_SLOT_PIN][QDCR_PIN_IN_BIT]
     && s.regs[QDCR_SLOT_PIN][QDCR_PIN_FUNC_LSB +: 4] == QDCR_FUNC_START
     && !(reg_write && reg_addr == QDCR_ADDR_TRIG))
      |=> (gen_run == ($past(gen_run)
                       ^ $past(s.regs[QDCR_SLOT_PIN][QDCR_PIN_CHEN_LSB +: 4]))))
    else $error("generator run flags did not toggle on pin edge");

endmodule : qdcr_bank
`default_nettype wire

// file: core/qdcr_input_filter.sv
// Conditioner for the general-purpose input: optional glitch filter and rise pulse.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module qdcr_input_filter
  import qdcr_pkg::*;
#(
  parameter logic [QDCR_FILT_CW-1:0] FILTER_CYCLES = QDCR_FILTER_CYCLES
) (
  input  wire logic clk,        // System clock
  input  wire logic reset_n,    // Synchronous reset
  input  wire logic ce,         // Clock enable
  input  wire logic filter_en,  // Glitch filter on
  input  wire logic pin_in,     // Raw pin level
  output logic      level,      // Conditioned level
  output logic      rise        // One-cycle pulse on a rising conditioned edge
);

  qdcr_filt_state_t s;       // Current state
  qdcr_filt_state_t next_s;  // Next state

  // Level follows the pin, or only after it held a new value long enough
  always_comb begin
    next_s      = s;
    next_s.rise = 1'b0;
    if (filter_en) begin
      if (pin_in == s.level) begin
        next_s.count = '0;  // Any bounce back restarts the count
      end else if (s.count >= FILTER_CYCLES - 1'b1) begin
        next_s.level = pin_in;
        next_s.rise  = pin_in;
        next_s.count = '0;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end else begin
      next_s.level = pin_in;
      next_s.rise  = pin_in & ~s.level;
      next_s.count = '0;
    end
  end

  // State register; reset wins over the clock enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise  = s.rise;

endmodule : qdcr_input_filter
`default_nettype wire

// file: core/qdcr_pkg.sv
// Shared constants and types of the quad converter configuration register bank.
// Assumes one 100 MHz clock; register offsets are the word addresses seen by the host.
package qdcr_pkg;

  // Register addresses
  localparam logic [7:0] QDCR_ADDR_CH0   = 8'h03;
  localparam logic [7:0] QDCR_ADDR_CH1   = 8'h09;
  localparam logic [7:0] QDCR_ADDR_CH2   = 8'h0f;
  localparam logic [7:0] QDCR_ADDR_CH3   = 8'h15;
  localparam logic [7:0] QDCR_ADDR_POWER = 8'h1f;
  localparam logic [7:0] QDCR_ADDR_TRIG  = 8'h20;
  localparam logic [7:0] QDCR_ADDR_PIN   = 8'h24;

  // Storage slots; the slot number is also the nonvolatile word index
  localparam logic [2:0] QDCR_SLOT_POWER = 3'h0;
  localparam logic [2:0] QDCR_SLOT_PIN   = 3'h1;
  localparam logic [2:0] QDCR_SLOT_CH0   = 3'h2;
  localparam logic [2:0] QDCR_SLOT_LAST  = 3'h5;
  localparam int         QDCR_NUM_SLOTS  = 6;

  // Shared power register fields
  localparam int QDCR_POW_LATCH_BIT = 15;
  localparam int QDCR_POW_LOCK_BIT  = 14;
  localparam int QDCR_POW_FDR_BIT   = 13;
  localparam int QDCR_POW_REF_BIT   = 12;

  // Pin function register fields
  localparam int QDCR_PIN_FILTER_BIT = 15;
  localparam int QDCR_PIN_OUT_BIT    = 13;
  localparam int QDCR_PIN_STAT_LSB   = 9;
  localparam int QDCR_PIN_CHEN_LSB   = 5;
  localparam int QDCR_PIN_FUNC_LSB   = 1;
  localparam int QDCR_PIN_IN_BIT     = 0;

  // Trigger register fields
  localparam int QDCR_TRIG_UNLOCK_LSB = 12;
  localparam int QDCR_TRIG_RESET_LSB  = 8;
  localparam int QDCR_TRIG_LOAD_BIT   = 7;
  localparam int QDCR_TRIG_CLEAR_BIT  = 6;
  localparam int QDCR_TRIG_FDUMP_BIT  = 4;
  localparam int QDCR_TRIG_PROT_BIT   = 3;
  localparam int QDCR_TRIG_FDREAD_BIT = 2;
  localparam int QDCR_TRIG_STORE_BIT  = 1;
  localparam int QDCR_TRIG_RELOAD_BIT = 0;

  // Channel register fields
  localparam int QDCR_CH_REF_LSB    = 10;
  localparam int QDCR_CH_ODRAIN_BIT = 4;
  localparam int QDCR_CH_TOPIN_BIT  = 3;
  localparam int QDCR_CH_FBZ_BIT    = 2;
  localparam int QDCR_CH_INV_BIT    = 1;
  localparam int QDCR_CH_EN_BIT     = 0;

  // Keys and codes
  localparam logic [3:0] QDCR_UNLOCK_KEY = 4'h5;
  localparam logic [3:0] QDCR_RESET_KEY  = 4'ha;
  localparam logic [3:0] QDCR_FUNC_START = 4'h8;

  // Writable bits; the rest read as zero
  localparam logic [15:0] QDCR_POWER_MASK = 16'hffff;
  localparam logic [15:0] QDCR_PIN_MASK   = 16'hbfff;
  localparam logic [15:0] QDCR_CH_MASK    = 16'h1c1f;

  // Values after reset, before the nonvolatile reload overwrites them
  localparam logic [15:0] QDCR_POWER_RST = 16'h0000;
  localparam logic [15:0] QDCR_PIN_RST   = 16'h0000;
  localparam logic [15:0] QDCR_CH_RST    = 16'h0000;

  // Glitch filter length in clock cycles
  localparam int         QDCR_FILT_CW        = 8;
  localparam logic [7:0] QDCR_FILTER_CYCLES  = 8'h04;

  // Nonvolatile sequencer states
  typedef enum logic [1:0] {QDCR_IDLE, QDCR_LOAD, QDCR_SAVE} qdcr_fsm_t;

  // Whole state of the register bank
  typedef struct packed {
    qdcr_fsm_t        fsm;
    logic [2:0]       idx;
    logic [5:0][15:0] regs;
    logic [3:0]       run;
    logic             pin_out;
    logic [15:0]      rdata;
    logic             rvalid;
    logic             load_pulse;
    logic             clear_pulse;
    logic             fdump_pulse;
    logic             protect_pulse;
    logic             fdread_pulse;
  } qdcr_state_t;

  // Whole state of the input conditioner
  typedef struct packed {
    logic                    level;
    logic                    rise;
    logic [QDCR_FILT_CW-1:0] count;
  } qdcr_filt_state_t;

endpackage : qdcr_pkg

// file: tb/qdcr_bank_bench.sv
// Self-checking bench for the register bank, with a store model as partner.
// Assumes the bank's decoded register port; inputs move 1 ns after each edge.
`timescale 1ns/10ps
`default_nettype none
module qdcr_bank_bench;
  import qdcr_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic general_input_pin = 1'b0, reg_rvalid, nvm_wr_en, nvm_busy, general_pin_out;
  logic general_pin_oe, comparator_latching, device_locked, fault_dump_read_disable;
  logic internal_ref_enable, output_load_strobe, output_clear, fault_dump_start;
  logic protect_start, fault_dump_read_start;
  logic [7:0]  reg_addr = 8'h00, voltage_output_power;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, nvm_rd_data, nvm_wr_data;
  logic [15:0] status_sources = 16'h0005;  // Fixed status pattern
  logic [2:0]  nvm_index;
  logic [3:0]  gen_run, current_output_power_down, chan_open_drain, chan_comp_to_pin;
  logic [3:0]  chan_feedback_low_z, chan_comp_invert, chan_comp_enable;
  logic [11:0] chan_ref_gain;
  int          n_errors = 0, cmp_count = 0;
  qdcr_bank DUT (.clk, .reset_n, .ce, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .nvm_rd_data, .nvm_index, .nvm_wr_en, .nvm_wr_data, .nvm_busy,
    .general_input_pin, .general_pin_out, .general_pin_oe, .status_sources, .gen_run,
    .comparator_latching, .device_locked, .fault_dump_read_disable, .internal_ref_enable,
    .voltage_output_power, .current_output_power_down, .chan_ref_gain, .chan_open_drain,
    .chan_comp_to_pin, .chan_feedback_low_z, .chan_comp_invert, .chan_comp_enable,
    .output_load_strobe, .output_clear, .fault_dump_start, .protect_start,
    .fault_dump_read_start);
  qdcr_store_model store (.clk, .nvm_index, .nvm_wr_en, .nvm_wr_data, .nvm_rd_data);
  // 100 MHz clock
  always #5 clk = ~clk;
  // Compare one value; widths up to 16 bits
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // One-cycle write strobe, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask : wr
  // One-cycle read strobe; data is checked in the valid cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1 reg_read = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_read = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
  endtask : rd
  // Bounded wait for a reload or store pass to end
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      if (nvm_busy === 1'b0) return;
      @(posedge clk);
      #1;
    end
    n_errors++;
    $display("[ERR] t=%0t seen=%h expected=%h", $time, nvm_busy, 1'b0);
    final_report();
  endtask : wait_idle
  initial begin
    logic [4:0] pulses;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    wait_idle();
    // Reload after reset fills every register from the store
    rd(QDCR_ADDR_POWER, 16'h0249);
    chk(current_output_power_down, 4'hf);
    chk(voltage_output_power, 8'h00);
    chk(internal_ref_enable, 1'b0);
    rd(QDCR_ADDR_PIN, 16'h01f1);
    rd(QDCR_ADDR_CH3, 16'h0400);
    chk(chan_ref_gain, 12'h249);
    $display("test reload done");
    // Don't-care bits read zero
    wr(QDCR_ADDR_CH0, 16'hffff);
    rd(QDCR_ADDR_CH0, 16'h1c1f);
    chk({chan_open_drain[0], chan_comp_to_pin[0], chan_feedback_low_z[0],
         chan_comp_invert[0], chan_comp_enable[0]}, 5'h1f);
    wr(QDCR_ADDR_PIN, 16'h41f1);
    rd(QDCR_ADDR_PIN, 16'h01f1);
    // Clock enable low freezes the bank, so this write must not land
    ce = 1'b0;
    wr(QDCR_ADDR_CH1, 16'h0000);
    ce = 1'b1;
    rd(QDCR_ADDR_CH1, 16'h0400);
    $display("test reserved done");
    // Each action bit gives its own pulse; only load, clear and fault-dump are checked to end after one cycle
    for (int i = 0; i < 5; i++) begin
      wr(QDCR_ADDR_TRIG, 16'h0001 << ((i < 2) ? 7 - i : 6 - i));
      pulses = {output_load_strobe, output_clear, fault_dump_start, protect_start,
                fault_dump_read_start};
      chk(pulses, 5'h10 >> i);
      @(posedge clk);
      #1 chk(output_load_strobe | output_clear | fault_dump_start, 1'b0);
    end
    rd(QDCR_ADDR_TRIG, 16'h0000);
    $display("test triggers done");
    // Rising pin edge toggles every enabled generator
    general_input_pin = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(gen_run, 4'hf);
    general_input_pin = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(gen_run, 4'hf);
    // Output mode drives the selected status bit one cycle after the write
    wr(QDCR_ADDR_PIN, 16'h21f1);
    @(posedge clk);
    #1 chk({general_pin_oe, general_pin_out}, 2'b11);
    wr(QDCR_ADDR_PIN, 16'h23f1);
    @(posedge clk);
    #1 chk({general_pin_oe, general_pin_out}, 2'b10);
    // Filtered input: a short glitch is dropped, a long rise toggles channel 0 only
    wr(QDCR_ADDR_PIN, 16'h8031);
    general_input_pin = 1'b1;
    repeat (2) @(posedge clk);
    #1 general_input_pin = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(gen_run, 4'hf);
    general_input_pin = 1'b1;
    repeat (7) @(posedge clk);
    #1 chk(gen_run, 4'he);
    $display("test pin done");
    // Store, overwrite, reload
    wr(QDCR_ADDR_POWER, 16'h1249);
    chk(internal_ref_enable, 1'b1);
    wr(QDCR_ADDR_TRIG, 16'h0002);
    chk(nvm_busy, 1'b1);
    wait_idle();
    chk(store.mem[0], 16'h1249);
    wr(QDCR_ADDR_POWER, 16'h0249);
    wr(QDCR_ADDR_TRIG, 16'h0001);
    wait_idle();
    rd(QDCR_ADDR_POWER, 16'h1249);
    $display("test store done");
    // Lock blocks writes until the right key
    wr(QDCR_ADDR_POWER, 16'hf249);
    chk({comparator_latching, device_locked, fault_dump_read_disable,
         internal_ref_enable}, 4'hf);
    wr(QDCR_ADDR_CH0, 16'h0000);
    rd(QDCR_ADDR_CH0, 16'h1c1f);
    wr(QDCR_ADDR_PIN, 16'h21f1);
    rd(QDCR_ADDR_PIN, 16'h8031);
    wr(QDCR_ADDR_TRIG, 16'h3000);
    chk(device_locked, 1'b1);
    wr(QDCR_ADDR_TRIG, 16'h5000);
    chk(device_locked, 1'b0);
    $display("test lock done");
    // Reset key restarts from the store
    wr(QDCR_ADDR_TRIG, 16'h0a00);
    wait_idle();
    // Channel 0 and power come back as saved by the earlier store pass
    rd(QDCR_ADDR_CH0, 16'h1c1f);
    rd(QDCR_ADDR_POWER, 16'h1249);
    chk(gen_run, 4'h0);
    $display("test reset key done");
    final_report();
  end
endmodule : qdcr_bank_bench
`default_nettype wire

// file: tb/qdcr_store_model.sv
// Behavioural nonvolatile word store facing the register bank.
// Assumes the bank reads it in the same cycle and writes on the store strobe.
`timescale 1ns/10ps
`default_nettype none
module qdcr_store_model
  import qdcr_pkg::*;
#(
  parameter logic [15:0] INIT_POWER = 16'h0249,
  parameter logic [15:0] INIT_PIN   = 16'h01f1,
  parameter logic [15:0] INIT_CH    = 16'h0400
) (
  input  wire logic        clk,          // System clock
  input  wire logic [2:0]  nvm_index,    // Word index from the bank
  input  wire logic        nvm_wr_en,    // Store strobe
  input  wire logic [15:0] nvm_wr_data,  // Word to keep
  output logic      [15:0] nvm_rd_data   // Word at the index
);
  logic [15:0] mem [QDCR_NUM_SLOTS];  // Stored words in slot order
  // Preload so that the first reload has known content
  initial begin
    mem[0] = INIT_POWER;
    mem[1] = INIT_PIN;
    for (int i = 2; i < QDCR_NUM_SLOTS; i++) begin
      mem[i] = INIT_CH;
    end
  end
  // Past the end a scrambled word shows, never a stale one
  assign nvm_rd_data = (nvm_index <= QDCR_SLOT_LAST) ? mem[nvm_index] : ~mem[0];
  // Keep each word presented during a store pass
  always @(posedge clk) begin
    if (nvm_wr_en && nvm_index <= QDCR_SLOT_LAST) begin
      mem[nvm_index] <= nvm_wr_data;
    end
  end
endmodule : qdcr_store_model
`default_nettype wire
